/* File: rtl/hps_host_port.sv */
/*
 Control half of an 8-bit parallel host port: strobe, data direction,
 write capture, open-drain service request, acknowledge handshake and
 fallback to general-purpose I/O.
 Assumes pins arrive asynchronously; one clock, synchronous reset.
*/
// Summary of operation
// - Strobe low: read drives bus, write listens
// - Capture write data on strobe rising edge
// - Open-drain request asks outside for service
// - Low acknowledge answers pending DMA request
// - Acknowledge also serves as interrupt acknowledge
// - Unselected port pins are GPIO, reset inputs
// - Request pin push-pull when used as GPIO
// - Bus released while strobe and acknowledge are both deasserted
// - Acknowledge during request drives the bus
// - Register select chooses accessed register
`timescale 1ns/1ps
`include "hps_cfg.svh"
module hps_host_port (
   input wire logic clk,
   input wire logic reset,
   input wire logic port_select,
   input wire logic host_enable_n,
   input wire logic transfer_direction,
   input wire hps_pkg::hps_sel_t register_select,
   input wire hps_pkg::hps_data_t host_data_bus_in,
   output hps_pkg::hps_data_t host_data_bus_out,
   output logic host_data_bus_oe,
   output logic service_request_n_out,
   output logic service_request_n_oe,
   input wire logic service_request_n_in,
   input wire logic acknowledge_in_n,
   input wire hps_pkg::hps_data_t read_data,
   output hps_pkg::hps_sel_t read_select,
   input wire logic request_set,
   output logic request_pending,
   output logic ack_pulse,
   output logic wr_valid,
   input wire logic wr_ready,
   output hps_pkg::hps_data_t wr_data,
   output hps_pkg::hps_sel_t wr_select,
   output logic wr_overrun,
   input wire logic [2:0] gpio_dir,
   input wire logic [2:0] gpio_out,
   output logic [2:0] gpio_in,
   output logic [2:0] gpio_oe,
   output logic [2:0] gpio_drive
);
   import hps_pkg::*;
   localparam int BW = `HPS_DATA_W + `HPS_SEL_W;

   // Two-stage synchronisers for every pin input
   logic [1:0] en_s_r;
   logic [1:0] ack_s_r;
   logic [1:0] dir_s_r;
   logic [1:0] req_s_r;
   hps_data_t data_s1_r;
   hps_data_t data_s2_r;
   hps_sel_t sel_s1_r;
   hps_sel_t sel_s2_r;
   logic en_d_r;
   logic ack_d_r;
   hps_data_t data_hold_r;
   hps_sel_t sel_hold_r;
   logic dir_hold_r;
   hps_req_state_t state_r;
   hps_req_state_t state_nxt;
   hps_data_t bus_out_r;
   logic bus_oe_r;
   logic req_out_r;
   logic req_oe_r;
   logic ack_pulse_r;
   logic overrun_r;
   logic [2:0] gin_r;
   logic [2:0] goe_r;
   logic [2:0] gdrv_r;
   logic buf_in_ready;
   logic [BW-1:0] buf_out;

   always_ff @(posedge clk) begin
      if (reset) begin
         en_s_r <= 2'h3;
         ack_s_r <= 2'h3;
         dir_s_r <= 2'h0;
         req_s_r <= 2'h3;
         data_s1_r <= 8'h00;
         data_s2_r <= 8'h00;
         sel_s1_r <= 3'h0;
         sel_s2_r <= 3'h0;
         en_d_r <= 1'b1;
         ack_d_r <= 1'b1;
      end else begin
         en_s_r <= {en_s_r[0], host_enable_n};
         ack_s_r <= {ack_s_r[0], acknowledge_in_n};
         dir_s_r <= {dir_s_r[0], transfer_direction};
         req_s_r <= {req_s_r[0], service_request_n_in};
         data_s1_r <= host_data_bus_in;
         data_s2_r <= data_s1_r;
         sel_s1_r <= register_select;
         sel_s2_r <= sel_s1_r;
         en_d_r <= en_s_r[1];
         ack_d_r <= ack_s_r[1];
      end
   end

   wire en_low = port_select && !en_s_r[1];
   wire ack_low = port_select && !ack_s_r[1];
   wire en_rise = port_select && en_s_r[1] && !en_d_r;
   wire ack_fall = port_select && !ack_s_r[1] && ack_d_r;
   wire host_write = en_low && !dir_s_r[1];
   wire host_read = en_low && dir_s_r[1];
   wire write_done = en_rise && !dir_hold_r;
   wire req_active = (state_r == HPS_REQ);
   wire ack_read = ack_low && (state_r != HPS_IDLE);
   wire drive_bus = host_read || ack_read;

   // Sample data and select while the strobe is low, commit on its rising edge
   always_ff @(posedge clk) begin
      if (reset) begin
         data_hold_r <= 8'h00;
         sel_hold_r <= 3'h0;
         dir_hold_r <= 1'b1;
      end else if (en_low) begin
         data_hold_r <= data_s2_r;
         sel_hold_r <= sel_s2_r;
         dir_hold_r <= dir_s_r[1];
      end
   end

   hps_buf2 #(.WIDTH(BW)) u_wbuf (
      .clk(clk),
      .reset(reset),
      .in_valid(write_done),
      .in_ready(buf_in_ready),
      .in_data({sel_hold_r, data_hold_r}),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data(buf_out)
   );
   assign wr_data = buf_out[`HPS_DATA_W-1:0];
   assign wr_select = buf_out[BW-1:`HPS_DATA_W];
   assign read_select = sel_s2_r;

   // Service request handshake
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         HPS_IDLE: begin
            if (request_set) begin
               state_nxt = HPS_REQ;
            end
         end
         HPS_REQ: begin
            if (ack_fall) begin
               state_nxt = HPS_ACKED;
            end
         end
         HPS_ACKED: begin
            if (!ack_low) begin
               state_nxt = request_set ? HPS_REQ : HPS_IDLE;
            end
         end
         default: state_nxt = HPS_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset || !port_select) begin
         state_r <= HPS_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end
   // One-hot request bit, straight from the state flip-flop
   assign request_pending = state_r[1];

   always_ff @(posedge clk) begin
      if (reset) begin
         bus_out_r <= 8'h00;
         bus_oe_r <= 1'b0;
         req_out_r <= 1'b0;
         req_oe_r <= 1'b0;
         ack_pulse_r <= 1'b0;
         overrun_r <= 1'b0;
      end else begin
         bus_out_r <= read_data;
         bus_oe_r <= drive_bus;
         ack_pulse_r <= req_active && ack_fall;
         overrun_r <= write_done && !buf_in_ready;
         if (port_select) begin
            req_out_r <= 1'b0;
            req_oe_r <= state_nxt == HPS_REQ;
         end else begin
            req_out_r <= gpio_out[1];
            req_oe_r <= gpio_dir[1];
         end
      end
   end

   // Fallback general-purpose I/O: enable, request, acknowledge pins
   always_ff @(posedge clk) begin
      if (reset) begin
         gin_r <= 3'h0;
         goe_r <= 3'h0;
         gdrv_r <= 3'h0;
      end else begin
         gin_r <= {ack_s_r[1], req_s_r[1], en_s_r[1]};
         goe_r <= port_select ? 3'h0 : {gpio_dir[2], 1'b0, gpio_dir[0]};
         gdrv_r <= gpio_out;
      end
   end

   assign host_data_bus_out = bus_out_r;
   assign host_data_bus_oe = bus_oe_r;
   assign service_request_n_out = req_out_r;
   assign service_request_n_oe = req_oe_r;
   assign ack_pulse = ack_pulse_r;
   assign wr_overrun = overrun_r;
   assign gpio_in = gin_r;
   assign gpio_oe = goe_r;
   assign gpio_drive = gdrv_r;
endmodule

/* File: rtl/hps_cfg.svh */
/*
 Constants for the host port strobe and handshake block.
 Assumes inclusion by the package and by hps_host_port.
*/
`ifndef HPS_CFG_SVH
`define HPS_CFG_SVH
`define HPS_DATA_W 8
`define HPS_SEL_W 3
`define HPS_BUF_DEPTH 2
`define HPS_SYNC_RST 1'b1
`endif

/* File: rtl/hps_pkg.sv */
/*
 Types for the host port strobe and handshake block.
 Assumes hps_cfg.svh is on the include path.
*/
`include "hps_cfg.svh"
package hps_pkg;
   typedef logic [`HPS_DATA_W-1:0] hps_data_t;
   typedef logic [`HPS_SEL_W-1:0] hps_sel_t;
   typedef enum logic [2:0] {
      HPS_IDLE = 3'b001,
      HPS_REQ = 3'b010,
      HPS_ACKED = 3'b100
   } hps_req_state_t;
endpackage

/* File: rtl/hps_buf2.sv */
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module hps_buf2 #(
   parameter int WIDTH = 11
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_r [0:1];
   logic wp_r;
   logic rp_r;
   logic [1:0] cnt_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data = mem_r[rp_r];
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         wp_r <= wp_r ^ push;
         rp_r <= rp_r ^ pop;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule

/* File: testbench/hps_host_port_asserts.sv */
/* Pin and stream assertions for hps_host_port.
 Assumes binding to every instance of hps_host_port. */
`timescale 1ns/1ps
module hps_host_port_asserts (
   input wire logic clk,
   input wire logic reset,
   input wire logic port_select,
   input wire logic host_enable_n,
   input wire logic transfer_direction,
   input wire logic acknowledge_in_n,
   input wire logic host_data_bus_oe,
   input wire logic service_request_n_oe,
   input wire logic service_request_n_out,
   input wire logic request_pending,
   input wire logic ack_pulse,
   input wire logic wr_valid,
   input wire logic wr_ready,
   input wire hps_pkg::hps_data_t wr_data,
   input wire logic [2:0] gpio_dir,
   input wire logic [2:0] gpio_out,
   input wire logic [2:0] gpio_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_read;
      (port_select && !host_enable_n && transfer_direction)[*5];
   endsequence
   sequence s_quiet;
      (host_enable_n && acknowledge_in_n)[*6];
   endsequence
   property p_read; s_read |-> host_data_bus_oe; endproperty
   property p_quiet; s_quiet |-> !host_data_bus_oe; endproperty
   property p_req; (port_select && request_pending)[*2] |-> service_request_n_oe && !service_request_n_out; endproperty
   property p_noreq; (port_select && !request_pending)[*2] |-> !service_request_n_oe; endproperty
   property p_ack; ack_pulse |-> $past(request_pending) ##1 !ack_pulse; endproperty
   property p_hold; wr_valid && !wr_ready |=> wr_valid && $stable(wr_data); endproperty
   property p_gpio;
      !port_select && !$past(port_select) && !$past(reset) |->
         service_request_n_oe == $past(gpio_dir[1]) && service_request_n_out == $past(gpio_out[1]);
   endproperty
   property p_rst; $past(reset) |-> gpio_oe == 3'h0 && !host_data_bus_oe && !service_request_n_oe; endproperty
   a_read: assert property (p_read) else $error("bus not driven on read");
   a_quiet: assert property (p_quiet) else $error("bus driven while idle");
   a_req: assert property (p_req) else $error("request not pulled low");
   a_noreq: assert property (p_noreq) else $error("request driven while idle");
   a_ack: assert property (p_ack) else $error("bad acknowledge pulse");
   a_hold: assert property (p_hold) else $error("write word changed while stalled");
   a_gpio: assert property (p_gpio) else $error("request pin not push-pull");
   a_rst: assert property (p_rst) else $error("pins not inputs after reset");
endmodule
bind hps_host_port hps_host_port_asserts hps_host_port_asserts_inst (.*);

/* File: testbench/hps_host_model.sv */
/* Host processor model driving strobe, direction, select, data, acknowledge.
 Assumes the bench resolves the shared data bus. */
`timescale 1ns/1ps
module hps_host_model (
   input wire logic clk,
   output logic host_enable_n,
   output logic transfer_direction,
   output hps_pkg::hps_sel_t register_select,
   output hps_pkg::hps_data_t data_drive,
   output logic acknowledge_in_n
);
   import hps_pkg::*;
   logic cs = 0, en = 0;
   assign host_enable_n = ~(cs & en);
   initial begin
      transfer_direction = 0;
      register_select = 3'h0;
      data_drive = 8'h5a;
      acknowledge_in_n = 1;
   end
   task automatic access(input logic rd, input hps_sel_t s, input hps_data_t d, input int hold);
      @(posedge clk);
      cs <= 1;
      transfer_direction <= rd;
      register_select <= s;
      data_drive <= rd ? ~data_drive : d;
      @(posedge clk) en <= 1;
      repeat (hold) @(posedge clk);
      en <= 0;
      @(posedge clk);
      cs <= 0;
      data_drive <= ~d;
      register_select <= ~s;
      repeat (3) @(posedge clk);
   endtask
   task automatic ack(input int hold);
      @(posedge clk) acknowledge_in_n <= 0;
      repeat (hold) @(posedge clk);
      acknowledge_in_n <= 1;
      repeat (3) @(posedge clk);
   endtask
endmodule

/* File: testbench/hps_host_port_bench.sv */
/* Self-checking bench for hps_host_port.
 Assumes hps_host_model on the far side and a pull-up on the request pin. */
`timescale 1ns/1ps
module hps_host_port_bench;
   import hps_pkg::*;
   logic clk = 0, reset = 1, port_select = 1, request_set = 0, wr_ready = 0, ovr_seen = 0, ack_seen = 0;
   logic [2:0] gpio_dir = 0, gpio_out = 0, gpio_in, gpio_oe, gpio_drive;
   hps_data_t read_data = 8'hc3, bus_out, drv, wr_data;
   hps_sel_t sel, rsel, wr_select;
   logic en_n, dir, ack_n, bus_oe, rq_out, rq_oe, pend, ackp, wr_valid, ovr;
   int n_errors = 0, total_checks = 0, cycles = 0;
   always #4 clk = ~clk;
   hps_host_model hps_host_model_inst (.clk(clk), .host_enable_n(en_n), .transfer_direction(dir),
      .register_select(sel), .data_drive(drv), .acknowledge_in_n(ack_n));
   hps_host_port hps_host_port_inst (.clk(clk), .reset(reset), .port_select(port_select),
      .host_enable_n(en_n), .transfer_direction(dir), .register_select(sel),
      .host_data_bus_in(bus_oe ? bus_out : drv), .host_data_bus_out(bus_out), .host_data_bus_oe(bus_oe),
      .service_request_n_out(rq_out), .service_request_n_oe(rq_oe), .service_request_n_in(rq_oe ? rq_out : 1'b1),
      .acknowledge_in_n(ack_n), .read_data(read_data), .read_select(rsel), .request_set(request_set),
      .request_pending(pend), .ack_pulse(ackp), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
      .wr_select(wr_select), .wr_overrun(ovr), .gpio_dir(gpio_dir), .gpio_out(gpio_out), .gpio_in(gpio_in),
      .gpio_oe(gpio_oe), .gpio_drive(gpio_drive));
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task end_of_test;
      if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (ovr) ovr_seen <= 1;
      if (ackp) ack_seen <= 1;
      if (cycles == 3000) begin
         n_errors++;
         end_of_test();
      end
   end
   task automatic pop(input hps_data_t d, input hps_sel_t s);
      int n = 0;
      while (wr_valid !== 1'b1 && n < 20) begin
         step(1);
         n++;
      end
      chk("wr_data", wr_data, d);
      chk("wr_select", {5'h0, wr_select}, {5'h0, s});
      @(posedge clk) wr_ready <= 1;
      @(posedge clk) wr_ready <= 0;
      #1;
   endtask
   task t_write;
      hps_host_model_inst.access(0, 3'h1, 8'h3c, 4);
      hps_host_model_inst.access(0, 3'h6, 8'ha5, 4);
      hps_host_model_inst.access(0, 3'h3, 8'h0f, 4);
      step(1);
      chk("overrun", ovr_seen, 1);
      pop(8'h3c, 3'h1);
      pop(8'ha5, 3'h6);
      step(3);
      chk("wr_valid", wr_valid, 0);
   endtask
   task t_read;
      fork
         hps_host_model_inst.access(1, 3'h2, 8'h00, 6);
         begin
            step(7);
            chk("bus_oe", bus_oe, 1);
            chk("bus_out", bus_out, read_data);
            chk("read_select", {5'h0, rsel}, 8'h02);
         end
      join
      step(1);
      chk("bus_oe", bus_oe, 0);
   endtask
   task t_request;
      @(posedge clk) request_set <= 1;
      @(posedge clk) request_set <= 0;
      step(2);
      chk("pending", pend, 1);
      chk("req_oe", rq_oe, 1);
      chk("req_out", rq_out, 0);
      fork
         hps_host_model_inst.ack(6);
         begin
            step(6);
            chk("bus_oe", bus_oe, 1);
         end
      join
      step(2);
      chk("ack_pulse", ack_seen, 1);
      chk("req_oe", rq_oe, 0);
      chk("bus_oe", bus_oe, 0);
   endtask
   task t_gpio;
      @(posedge clk) begin
         port_select <= 0;
         gpio_dir <= 3'h7;
      end
      step(3);
      chk("gpio_oe", gpio_oe, 8'h05);
      chk("req_oe", rq_oe, 1);
      chk("req_out", rq_out, 0);
      @(posedge clk) gpio_out <= 3'h2;
      step(2);
      chk("req_out", rq_out, 1);
      chk("gpio_in", {5'h0, gpio_in}, 8'h05);
      chk("gpio_drive", {5'h0, gpio_drive}, 8'h02);
      hps_host_model_inst.access(0, 3'h0, 8'h77, 4);
      step(1);
      chk("wr_valid", wr_valid, 0);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      reset <= 0;
      step(1);
      chk("gpio_oe", gpio_oe, 0);
      chk("req_oe", rq_oe, 0);
      t_write;
      t_read;
      t_request;
      t_gpio;
      end_of_test;
   end
endmodule
